// *** src/nlr_pkg.sv ***
/*
  Constants, commands and state type for the NAND LUN status and page read logic.
  Assumes one LUN per instance, x8 bus, and an array that streams a page in bytes.
*/
package nlr_pkg;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_CACHE_SEQ = 8'h31;
  localparam logic [7:0] CMD_CACHE_END = 8'h3F;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ADDR = 8'h78;

  // ----------------------------------------------------------------
  // Geometry and address layout
  // ----------------------------------------------------------------
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_IDX_W = 4;
  localparam int COL_W = 16;
  localparam int ROW_W = 24;
  localparam int ADDR_BUF_W = 40;
  localparam int ROW_POS = 16;
  localparam int LUN_LSB = 20;
  localparam int LUN_W = 2;
  localparam logic [2:0] ADDR_CNT_READ = 3'h5;
  localparam logic [2:0] ADDR_CNT_STATUS = 3'h3;
  localparam logic [COL_W-1:0] COL_START = 16'h0000;
  localparam logic [ROW_W-1:0] ROW_STEP = 24'h000001;
  localparam logic [PAGE_IDX_W-1:0] IDX_STEP = 4'h1;
  localparam logic [7:0] PAST_END_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int STAT_WP = 7;
  localparam int STAT_RDY = 6;
  localparam int STAT_ARR_IDLE = 5;
  localparam int STAT_MAKER = 4;
  localparam int STAT_CMD = 3;
  localparam int STAT_RSV = 2;
  localparam int STAT_PRIOR_ERR = 1;
  localparam int STAT_LAST_ERR = 0;
  localparam logic STAT_RSV_VAL = 1'b0;
  localparam logic STAT_CMD_VAL = 1'b0;
  localparam logic STAT_PRIOR_ERR_VAL = 1'b0;
  localparam logic STAT_LAST_ERR_VAL = 1'b0;

  // ----------------------------------------------------------------
  // Pin synchroniser order and idle levels
  // ----------------------------------------------------------------
  localparam int PIN_W = 14;
  localparam logic [PIN_W-1:0] PIN_IDLE = 14'h3C00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_COPY = 2'b11,
    ST_WAIT = 2'b10
  } nlr_state_type;

  function automatic logic [LUN_W-1:0] lun_of(input logic [ROW_W-1:0] row);
    lun_of = row[LUN_LSB +: LUN_W];
  endfunction

endpackage

// *** src/nlr_pin_sync.sv ***
/*
  Three-stage synchroniser for bus pins; a change is taken once stages two and three agree.
  Assumes asynchronous pins and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module nlr_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      level_q <= IDLE;
    end else begin
      for (int k = 0; k < W; k++) begin
        if (s2_q[k] == s3_q[k]) begin
          level_q[k] <= s3_q[k];
        end
      end
    end
  end

  assign o_level = level_q;
endmodule

// *** src/nlr_addr_collect.sv ***
/*
  Collects address cycles, least significant byte first, and counts them.
  Assumes one strobe per address byte from the same clock domain.
*/
`timescale 1ns/1ps
module nlr_addr_collect (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic [2:0] o_count,
  output logic [nlr_pkg::ADDR_BUF_W-1:0] o_bytes
);
  logic [2:0] count_q;
  logic [nlr_pkg::ADDR_BUF_W-1:0] bytes_q;

  always_ff @(posedge i_clk) begin
    if (i_reset || i_clear) begin
      count_q <= 3'h0;
      bytes_q <= '0;
    end else if (i_valid) begin
      if (count_q != nlr_pkg::ADDR_CNT_READ) begin
        count_q <= count_q + 3'h1;
      end
      bytes_q <= {i_byte, bytes_q[nlr_pkg::ADDR_BUF_W-1:8]};
    end
  end

  assign o_count = count_q;
  assign o_bytes = bytes_q;
endmodule

// *** src/nlr_lun.sv ***
/*
  One NAND LUN: status byte, addressed status selection, page read, cached read pipeline.
  Assumes host bus pins are asynchronous and the array streams page bytes on i_clk.
*/
`timescale 1ns/1ps
module nlr_lun #(
  parameter logic [nlr_pkg::LUN_W-1:0] THIS_LUN = 2'h0,
  parameter logic MAKER_FLAG = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_enable_strobe_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic o_ready_busy_out,
  output logic o_ready_busy_oe,
  output logic o_array_fetch,
  output logic [nlr_pkg::ROW_W-1:0] o_array_row,
  input wire logic i_array_valid,
  input wire logic [7:0] i_array_data,
  input wire logic i_array_last
);
  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  logic [nlr_pkg::PIN_W-1:0] pins;
  logic ce_n_s, cle_s, ale_s, we_n_s, rd_n_s, wp_n_s;
  logic [7:0] dq_s;
  logic we_n_p_q, rd_n_p_q;
  logic we_rise, rd_fall;
  logic cmd_ev, addr_ev;

  nlr_pin_sync #(
    .W(nlr_pkg::PIN_W),
    .IDLE(nlr_pkg::PIN_IDLE)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin({i_ce_n, i_we_n, i_read_enable_strobe_n, i_wp_n, i_cle, i_ale, i_dq}),
    .o_level(pins)
  );

  assign {ce_n_s, we_n_s, rd_n_s, wp_n_s, cle_s, ale_s, dq_s} = pins;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      we_n_p_q <= 1'b1;
      rd_n_p_q <= 1'b1;
    end else begin
      we_n_p_q <= we_n_s;
      rd_n_p_q <= rd_n_s;
    end
  end

  assign we_rise = we_n_s && !we_n_p_q && !ce_n_s;
  assign rd_fall = !rd_n_s && rd_n_p_q && !ce_n_s;
  assign cmd_ev = we_rise && cle_s && !ale_s;
  assign addr_ev = we_rise && ale_s && !cle_s;

  // ----------------------------------------------------------------
  // Address cycles
  // ----------------------------------------------------------------
  logic [2:0] addr_cnt;
  logic [nlr_pkg::ADDR_BUF_W-1:0] addr_bytes;
  logic [nlr_pkg::ROW_W-1:0] addr_row;
  logic [nlr_pkg::COL_W-1:0] addr_col;

  nlr_addr_collect u_addr (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clear(cmd_ev),
    .i_valid(addr_ev),
    .i_byte(dq_s),
    .o_count(addr_cnt),
    .o_bytes(addr_bytes)
  );

  assign addr_row = addr_bytes[nlr_pkg::ROW_POS +: nlr_pkg::ROW_W];
  assign addr_col = addr_bytes[nlr_pkg::COL_W-1:0];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  nlr_pkg::nlr_state_type st_q;
  logic [7:0] cmd_q;
  logic sel_done_q;
  logic selected_q;
  logic sel_ev, lun_hit;
  logic rdy, fetching_q, arr_idle;
  logic read_go, cache_go, cache_end_go;
  logic cache_armed_q;

  assign rdy = (st_q == nlr_pkg::ST_IDLE);
  assign arr_idle = rdy && !fetching_q;
  assign lun_hit = (nlr_pkg::lun_of(addr_row) == THIS_LUN);
  assign sel_ev = (cmd_q == nlr_pkg::CMD_STATUS_ADDR) && (addr_cnt == nlr_pkg::ADDR_CNT_STATUS) && !sel_done_q;
  assign read_go = cmd_ev && (dq_s == nlr_pkg::CMD_READ_CONFIRM) && rdy
                   && (addr_cnt == nlr_pkg::ADDR_CNT_READ) && lun_hit;
  assign cache_go = cmd_ev && (dq_s == nlr_pkg::CMD_CACHE_SEQ) && rdy && selected_q && cache_armed_q;
  assign cache_end_go = cmd_ev && (dq_s == nlr_pkg::CMD_CACHE_END) && rdy && selected_q && cache_armed_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cmd_q <= 8'h00;
      sel_done_q <= 1'b0;
    end else if (cmd_ev) begin
      cmd_q <= dq_s;
      sel_done_q <= 1'b0;
    end else if (sel_ev) begin
      sel_done_q <= 1'b1;
    end
  end

  // Addressed status picks the answering LUN
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      selected_q <= 1'b1;
    end else if (sel_ev) begin
      selected_q <= lun_hit;
    end else if (cmd_ev && (dq_s == nlr_pkg::CMD_READ_CONFIRM) && (addr_cnt == nlr_pkg::ADDR_CNT_READ)) begin
      selected_q <= lun_hit;
    end
  end

  // ----------------------------------------------------------------
  // Output mode
  // ----------------------------------------------------------------
  logic out_status_q, out_data_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      out_status_q <= 1'b0;
      out_data_q <= 1'b0;
    end else if (cmd_ev) begin
      out_status_q <= (dq_s == nlr_pkg::CMD_STATUS) || (dq_s == nlr_pkg::CMD_STATUS_ADDR);
      out_data_q <= (dq_s == nlr_pkg::CMD_READ_SETUP) || read_go || cache_go || cache_end_go;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [nlr_pkg::ROW_W-1:0] row_q;
  logic launch_after_q;
  logic copy_now;

  assign copy_now = (st_q == nlr_pkg::ST_COPY);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= nlr_pkg::ST_IDLE;
      launch_after_q <= 1'b0;
    end else begin
      case (st_q)
        nlr_pkg::ST_IDLE: begin
          if (read_go) begin
            st_q <= nlr_pkg::ST_FETCH;
            launch_after_q <= 1'b0;
          end else if (cache_go || cache_end_go) begin
            st_q <= nlr_pkg::ST_WAIT;
            launch_after_q <= cache_go;
          end
        end
        nlr_pkg::ST_FETCH: begin
          if (!fetching_q) begin
            st_q <= nlr_pkg::ST_COPY;
          end
        end
        nlr_pkg::ST_WAIT: begin
          if (!fetching_q) begin
            st_q <= nlr_pkg::ST_COPY;
          end
        end
        nlr_pkg::ST_COPY: begin
          st_q <= nlr_pkg::ST_IDLE;
        end
        default: begin
          st_q <= nlr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Cache commands allowed only after a page read or cache read
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cache_armed_q <= 1'b0;
    end else if (read_go || cache_go) begin
      cache_armed_q <= 1'b1;
    end else if (cache_end_go) begin
      cache_armed_q <= 1'b0;
    end
  end

  // Row of the next fetch: given address or next sequential page
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      row_q <= '0;
    end else if (read_go) begin
      row_q <= addr_row;
    end else if (cache_go) begin
      if (addr_cnt == nlr_pkg::ADDR_CNT_READ) begin
        row_q <= addr_row;
      end else begin
        row_q <= row_q + nlr_pkg::ROW_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Array fetch into the cache buffer
  // ----------------------------------------------------------------
  logic [7:0] cache_mem [nlr_pkg::PAGE_BYTES];
  logic [7:0] page_mem [nlr_pkg::PAGE_BYTES];
  logic [nlr_pkg::PAGE_IDX_W-1:0] fill_idx_q;
  logic launch;

  assign launch = (st_q == nlr_pkg::ST_IDLE) ? read_go : (copy_now && launch_after_q);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_array_fetch <= 1'b0;
      o_array_row <= '0;
    end else begin
      o_array_fetch <= launch;
      if (launch) begin
        o_array_row <= read_go ? addr_row : row_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fetching_q <= 1'b0;
      fill_idx_q <= '0;
    end else if (launch) begin
      fetching_q <= 1'b1;
      fill_idx_q <= '0;
    end else if (fetching_q && i_array_valid) begin
      fill_idx_q <= fill_idx_q + nlr_pkg::IDX_STEP;
      if (i_array_last) begin
        fetching_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (fetching_q && i_array_valid) begin
      cache_mem[fill_idx_q] <= i_array_data;
    end
  end

  // Copy latest fetched page into the page register
  always_ff @(posedge i_clk) begin
    if (copy_now) begin
      page_mem <= cache_mem;
    end
  end

  // ----------------------------------------------------------------
  // Column pointer and data out
  // ----------------------------------------------------------------
  logic [nlr_pkg::COL_W-1:0] col_q;
  logic [7:0] status_byte;
  logic [7:0] page_byte;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      col_q <= nlr_pkg::COL_START;
    end else if (read_go) begin
      col_q <= addr_col;
    end else if (cache_go || cache_end_go) begin
      col_q <= nlr_pkg::COL_START;
    end else if (rd_fall && out_data_q && !out_status_q && rdy) begin
      col_q <= col_q + 16'h0001;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[nlr_pkg::STAT_WP] = wp_n_s;
    status_byte[nlr_pkg::STAT_RDY] = rdy;
    status_byte[nlr_pkg::STAT_ARR_IDLE] = arr_idle;
    status_byte[nlr_pkg::STAT_MAKER] = MAKER_FLAG;
    status_byte[nlr_pkg::STAT_CMD] = nlr_pkg::STAT_CMD_VAL;
    status_byte[nlr_pkg::STAT_RSV] = nlr_pkg::STAT_RSV_VAL;
    status_byte[nlr_pkg::STAT_PRIOR_ERR] = nlr_pkg::STAT_PRIOR_ERR_VAL;
    status_byte[nlr_pkg::STAT_LAST_ERR] = nlr_pkg::STAT_LAST_ERR_VAL;
  end

  assign page_byte = (col_q < nlr_pkg::COL_W'(nlr_pkg::PAGE_BYTES))
                     ? page_mem[col_q[nlr_pkg::PAGE_IDX_W-1:0]] : nlr_pkg::PAST_END_BYTE;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_dq <= 8'h00;
    end else if (rd_fall) begin
      o_dq <= (out_status_q || !rdy) ? status_byte : page_byte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_dq_oe <= 1'b0;
    end else begin
      o_dq_oe <= !ce_n_s && !rd_n_s && !cle_s && !ale_s && selected_q
                 && (out_status_q || out_data_q) && !sel_ev;
    end
  end

  // ----------------------------------------------------------------
  // Ready/busy pin, open drain
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ready_busy_out <= 1'b0;
      o_ready_busy_oe <= 1'b0;
    end else begin
      o_ready_busy_out <= 1'b0;
      o_ready_busy_oe <= !rdy;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_cache_issue;
    cache_go || cache_end_go;
  endsequence
  sequence s_busy_two;
    !status_byte[nlr_pkg::STAT_RDY] ##1 o_ready_busy_oe;
  endsequence

  property p_deselect;
    (sel_ev && !lun_hit) |=> (!o_dq_oe)[*4];
  endproperty
  a_deselect: assert property (p_deselect) else $error("unselected LUN drives bus");

  property p_busy_pin;
    !rdy |=> o_ready_busy_oe && !o_ready_busy_out;
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy pin not pulled low");

  property p_cache_busy;
    s_cache_issue |=> s_busy_two;
  endproperty
  a_cache_busy: assert property (p_cache_busy) else $error("cache command did not go busy");

  property p_array_idle_flag;
    o_array_fetch |-> !status_byte[nlr_pkg::STAT_ARR_IDLE];
  endproperty
  a_array_idle_flag: assert property (p_array_idle_flag) else $error("array idle during fetch");

  property p_wp;
    (rd_fall && out_status_q) |=> o_dq[nlr_pkg::STAT_WP] == $past(wp_n_s);
  endproperty
  a_wp: assert property (p_wp) else $error("write flag wrong");

  property p_col_zero;
    s_cache_issue |=> col_q == nlr_pkg::COL_START;
  endproperty
  a_col_zero: assert property (p_col_zero) else $error("cache output not at column zero");

  property p_end_no_fetch;
    cache_end_go |=> (!o_array_fetch)[*4];
  endproperty
  a_end_no_fetch: assert property (p_end_no_fetch) else $error("cache end launched a fetch");

  property p_read_col;
    read_go |=> col_q == $past(addr_col) ##0 !rdy;
  endproperty
  a_read_col: assert property (p_read_col) else $error("read column not loaded");

  property p_copy_ready;
    (copy_now && !launch_after_q) |=> rdy ##1 !o_ready_busy_oe;
  endproperty
  a_copy_ready: assert property (p_copy_ready) else $error("ready not after copy");

  property p_status_fixed;
    (rd_fall && out_status_q) |=> o_dq[nlr_pkg::STAT_PRIOR_ERR] == 1'b0 && o_dq[nlr_pkg::STAT_RSV] == 1'b0;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("fixed status bits set");
endmodule

// *** dv/nlr_host_model.sv ***
/*
  Host flash controller model: command, address and read strobe cycles on the x8 bus.
  Assumes the LUN samples its pins through synchronisers, so each level holds at least six clocks (read strobe low holds eight).
*/
`timescale 1ns/1ps
module nlr_host_model (
  input wire logic i_clk,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_rd_n,
  output logic [7:0] o_dq,
  input wire logic [7:0] i_dq,
  input wire logic i_dq_oe
);
  // ----------------------------------------------------------------
  // Idle pins
  // ----------------------------------------------------------------
  initial begin
    o_ce_n = 1'b1;
    o_cle = 1'b0;
    o_ale = 1'b0;
    o_we_n = 1'b1;
    o_rd_n = 1'b1;
    o_dq = 8'h00;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic bus_write(input logic cle, input logic ale, input logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_ce_n = 1'b0;
    o_cle = cle;
    o_ale = ale;
    o_dq = b;
    o_we_n = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    o_we_n = 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
    o_cle = 1'b0;
    o_ale = 1'b0;
    o_dq = ~b;
  endtask

  // Single-rate bus, one copy latched per strobe
  task automatic bus_read(output logic [7:0] d, output logic oe);
    @(posedge i_clk);
    #1;
    o_rd_n = 1'b0;
    repeat (8) @(posedge i_clk);
    #1;
    d = i_dq;
    oe = i_dq_oe;
    o_rd_n = 1'b1;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// *** dv/tb_nlr_lun.sv ***
/*
  Self-checking bench for one LUN: status byte, page read, cached reads, LUN selection.
  Assumes THIS_LUN 0, MAKER_FLAG 0 and an array source that starts streaming 60 clocks late.
*/
`timescale 1ns/1ps
module tb_nlr_lun;
  logic i_clk, i_reset, i_wp_n, ce_n, cle, ale, we_n, rd_n, busy_seen;
  logic i_array_valid, i_array_last, o_dq_oe, o_ready_busy_oe, o_array_fetch, o_ready_busy_out;
  logic [7:0] dq_in, o_dq, i_array_data, d;
  logic [23:0] o_array_row, arow;
  logic oe;
  int bad_count, checks, cycles, fetch_n, n;

  nlr_lun dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale),
    .i_we_n(we_n), .i_read_enable_strobe_n(rd_n), .i_wp_n(i_wp_n), .i_dq(dq_in), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .o_ready_busy_out(o_ready_busy_out), .o_ready_busy_oe(o_ready_busy_oe),
    .o_array_fetch(o_array_fetch), .o_array_row(o_array_row), .i_array_valid(i_array_valid),
    .i_array_data(i_array_data), .i_array_last(i_array_last));
  nlr_host_model host_u (.i_clk(i_clk), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
    .o_rd_n(rd_n), .o_dq(dq_in), .i_dq(o_dq), .i_dq_oe(o_dq_oe));

  // ----------------------------------------------------------------
  // Clock, monitors, array source
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  function automatic logic [7:0] arr_byte(input logic [23:0] r, input int k);
    return {r[3:0], k[3:0]};
  endfunction

  always @(negedge i_clk) begin
    if (o_array_fetch === 1'b1) fetch_n++;
    if (o_ready_busy_oe === 1'b1) busy_seen = 1'b1;
  end

  initial begin
    i_array_valid = 1'b0;
    i_array_data = 8'h00;
    i_array_last = 1'b0;
    forever begin
      @(negedge i_clk);
      if (o_array_fetch === 1'b1) begin
        arow = o_array_row;
        repeat (60) @(posedge i_clk);
        for (int k = 0; k < 16; k++) begin
          #1;
          i_array_valid = 1'b1;
          i_array_data = arr_byte(arow, k);
          i_array_last = (k == 15);
          @(posedge i_clk);
        end
        #1;
        i_array_valid = 1'b0;
        i_array_last = 1'b0;
        i_array_data = 8'hA5;
      end
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] b);
    host_u.bus_write(1'b1, 1'b0, b);
  endtask

  task automatic adr(input logic [7:0] b);
    host_u.bus_write(1'b0, 1'b1, b);
  endtask

  task automatic addr5(input logic [15:0] col, input logic [23:0] row);
    adr(col[7:0]);
    adr(col[15:8]);
    adr(row[7:0]);
    adr(row[15:8]);
    adr(row[23:16]);
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 400 && !(busy_seen && o_ready_busy_oe === 1'b0); i++) @(negedge i_clk);
    check1("busy seen", 1'b1, busy_seen);
    check1("ready reached", 1'b0, o_ready_busy_oe);
  endtask

  task automatic page_read(input logic [15:0] col, input logic [23:0] row);
    cmd(8'h00);
    addr5(col, row);
    busy_seen = 1'b0;
    cmd(8'h30);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_status_reset();
    cmd(8'h70);
    host_u.bus_read(d, oe);
    check8("idle status", 8'hE0, d);
    check1("status drive", 1'b1, oe);
    @(posedge i_clk);
    #1;
    i_wp_n = 1'b0;
    repeat (8) @(posedge i_clk);
    host_u.bus_read(d, oe);
    check8("protected status", 8'h60, d);
    #1;
    i_wp_n = 1'b1;
    check1("busy pin idle", 1'b0, o_ready_busy_oe);
    check1("busy pin value", 1'b0, o_ready_busy_out);
  endtask

  task automatic t_page_read();
    page_read(16'h000E, 24'h000005);
    cmd(8'h70);
    host_u.bus_read(d, oe);
    check8("busy status top", 8'h80, d & 8'hC0);
    check1("busy pin low", 1'b1, o_ready_busy_oe);
    check1("busy pin level", 1'b0, o_ready_busy_out);
    wait_ready();
    cmd(8'h70);
    host_u.bus_read(d, oe);
    check8("done status", 8'hE0, d);
    cmd(8'h00);
    host_u.bus_read(d, oe);
    check8("byte 14", arr_byte(24'h5, 14), d);
    check1("data drive", 1'b1, oe);
    host_u.bus_read(d, oe);
    check8("byte 15", arr_byte(24'h5, 15), d);
    host_u.bus_read(d, oe);
    check8("past end", 8'hFF, d);
  endtask

  task automatic t_cache();
    page_read(16'h0004, 24'h000007);
    wait_ready();
    n = fetch_n;
    busy_seen = 1'b0;
    cmd(8'h31);
    wait_ready();
    check1("next fetch", 1'b1, fetch_n == n + 1);
    check8("next row", 8'h08, o_array_row[7:0]);
    cmd(8'h70);
    host_u.bus_read(d, oe);
    check8("array busy status", 8'hC0, d);
    cmd(8'h00);
    host_u.bus_read(d, oe);
    check8("cached byte 0", arr_byte(24'h7, 0), d);
    cmd(8'h00);
    addr5(16'h0009, 24'h000003);
    busy_seen = 1'b0;
    cmd(8'h31);
    wait_ready();
    check8("random row", 8'h03, o_array_row[7:0]);
    cmd(8'h00);
    host_u.bus_read(d, oe);
    check8("random byte 0", arr_byte(24'h8, 0), d);
    n = fetch_n;
    busy_seen = 1'b0;
    cmd(8'h3F);
    wait_ready();
    cmd(8'h00);
    host_u.bus_read(d, oe);
    check8("final byte 0", arr_byte(24'h3, 0), d);
    check1("no fetch on end", 1'b1, fetch_n == n);
    busy_seen = 1'b0;
    cmd(8'h3F);
    repeat (20) @(posedge i_clk);
    check1("second end refused", 1'b0, busy_seen);
  endtask

  task automatic t_lun_select();
    cmd(8'h78);
    adr(8'h00);
    adr(8'h00);
    adr(8'h10);
    host_u.bus_read(d, oe);
    check1("other lun drive", 1'b0, oe);
    cmd(8'h78);
    adr(8'hFF);
    adr(8'hFF);
    adr(8'hCF);
    host_u.bus_read(d, oe);
    check1("own lun drive", 1'b1, oe);
    check8("own lun status", 8'hE0, d);
    cmd(8'h00);
    host_u.bus_read(d, oe);
    check8("selected data", arr_byte(24'h3, 1), d);
    check1("selected drive", 1'b1, oe);
  endtask

  task automatic report_and_stop();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    i_wp_n = 1'b1;
    repeat (10) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    t_status_reset();
    t_page_read();
    t_cache();
    t_lun_select();
    report_and_stop();
  end
endmodule
